// ### verilog/pwsc_top.sv
// Purpose: status, control and reset logic around a phase-locked loop
// Assumes: loop macro sits outside; all loop I/O are plain ports
// Notes: registers exist as plain ports, no bus
// How it works
// RULE1: signals not held in register mode leave as top ports.
// RULE2: each optional signal selects export or register mode; code has modes for loop reset and detector enable only.
// RULE3: loop reset pulses automatically after configuration reset.
// RULE4: system reset stays asserted until synchronised lock is seen.
// RULE5: any loop reset, port or bit, also resets the whole system.
// RULE6: loop reset restores initial settings; absent input means configuration-only reset.
// RULE7: register variant drives detector enable only from its control bit.
// RULE8: lock, enable and loop reset always exist as ports.
// RULE9: enable input switches loop on; absent means always enabled.
// RULE10: detector enable lets loop track; absent means enabled.
// RULE11: lock output follows loop lock state.
// RULE12: external clocks go only to pins; internal clocks may clock logic.
// RULE13: status bit0 lock resets 1, bit1 phase-done resets 0.
// RULE14: writes to status change nothing.
// RULE15: control bit0 one starts reset, bit1 zero disables detector; reset 0,1.
// RULE16: phase-done is synchronised before being read.
// RULE17: master writes zero to reserved bits, ignores their read value.
// RULE18: lock synchronised before it releases system reset.
`include "pwsc_params.svh"
`default_nettype none
module pwsc_top #(
  parameter pwsc_pkg::pwsc_mode_t RESET_MODE = pwsc_pkg::PWSC_REGISTER, // loop reset access
  parameter pwsc_pkg::pwsc_mode_t PFD_MODE = pwsc_pkg::PWSC_REGISTER, // detector access
  parameter bit HAS_RESET_IN = 1'b1, // loop reset input created
  parameter bit HAS_ENABLE_IN = 1'b1, // loop enable input created
  parameter bit HAS_PFD_IN = 1'b1, // detector enable input created
  parameter bit BUILTIN_REGS = 1'b0, // variant with built-in registers
  parameter int PULSE_CYC = `PWSC_PULSE_CYC // loop reset pulse length
) (
  input wire logic clk, // system (reference) clock
  input wire logic rst, // configuration reset
  input wire logic ce, // clock enable
  input wire logic loop_reset_in, // loop reset port
  input wire logic loop_enable_in, // loop enable port
  input wire logic pfd_enable_in, // detector enable port
  input wire logic status_wr, // status write strobe
  input wire logic [1:0] status_wdata, // status write data
  input wire logic ctrl_wr, // control write strobe
  input wire logic [1:0] ctrl_wdata, // control write data
  input wire logic loop_locked_raw, // lock from the loop, async
  input wire logic loop_phase_done_raw, // phase-done from loop, async
  output logic [1:0] status_rdata, // status word
  output logic [1:0] ctrl_rdata, // control word
  output logic loop_reset, // reset to the loop
  output logic loop_enable, // enable to the loop
  output logic loop_pfd_enable, // detector enable to the loop
  output logic locked, // lock indication
  output logic sys_reset // system-wide reset
);
  import pwsc_pkg::*;
  ////////////////////////////////////////////////////////////////////////////
  localparam int CW = $clog2(PULSE_CYC + 1);
  logic [1:0] synced;
  logic [1:0] ctrl;
  logic [CW-1:0] pulse_cnt;
  logic ext_reset;
  logic reg_reset_req;
  logic next_loop_reset;
  pwsc_state_t state;
  localparam int GW = $clog2(`PWSC_LOCK_GUARD_CYC + 1);
  logic [GW-1:0] guard_cnt;
  logic guard_done;

  // one place decides what restarts the loop, used from wait and run alike
  function automatic logic restart_req(input logic ext, input logic reg_req);
    return ext || reg_req;
  endfunction

  // lock and phase-done cross in; raw outputs stay unsynchronised
  pwsc_sync #(.WIDTH(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .d({loop_phase_done_raw, loop_locked_raw}), // RULE16 RULE18
    .q(synced)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control register; status has no write path at all
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl <= `PWSC_CTRL_RST; // RULE15
    end else if (ce) begin
      if (ctrl_wr) begin
        ctrl <= ctrl_wdata; // RULE15 RULE17
      end else if (pulse_cnt == CW'(1)) begin
        ctrl[`PWSC_CTRL_RESET_BIT] <= 1'b0;
      end
    end
  end
  // status_wr and status_wdata are deliberately unused RULE14

  assign reg_reset_req = (RESET_MODE == PWSC_REGISTER || BUILTIN_REGS) &&
                         ctrl[`PWSC_CTRL_RESET_BIT]; // RULE2
  assign ext_reset = (RESET_MODE == PWSC_EXPORT || BUILTIN_REGS) &&
                     HAS_RESET_IN && loop_reset_in; // RULE1 RULE6 RULE8

  ////////////////////////////////////////////////////////////////////////////
  // reset sequencer: configuration pulse, then wait for lock
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= PWSC_ST_CONFIG; // RULE3
      pulse_cnt <= CW'(PULSE_CYC);
    end else if (ce) begin
      unique case (state)
        PWSC_ST_CONFIG: begin
          if (pulse_cnt > CW'(1)) begin
            pulse_cnt <= pulse_cnt - CW'(1);
          end else begin
            pulse_cnt <= '0;
            state <= PWSC_ST_WAIT;
          end
        end
        PWSC_ST_WAIT: begin
          if (restart_req(ext_reset, reg_reset_req)) begin
            state <= PWSC_ST_CONFIG; // RULE5
            pulse_cnt <= CW'(PULSE_CYC);
          end else if (guard_done && synced[`PWSC_STAT_LOCK_BIT]) begin
            state <= PWSC_ST_RUN; // RULE4 RULE18
          end
        end
        PWSC_ST_RUN: begin
          if (restart_req(ext_reset, reg_reset_req)) begin
            state <= PWSC_ST_CONFIG; // RULE5
            pulse_cnt <= CW'(PULSE_CYC);
          end else if (!synced[`PWSC_STAT_LOCK_BIT]) begin
            state <= PWSC_ST_WAIT;
          end
        end
        default: begin
          state <= PWSC_ST_CONFIG;
        end
      endcase
    end
  end

  assign next_loop_reset = (state == PWSC_ST_CONFIG) || ext_reset; // RULE6

  ////////////////////////////////////////////////////////////////////////////
  // stale-lock guard: the synchroniser still shows the old lock for two
  // edges after a loop reset, so the wait state ignores it until this expires
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      guard_cnt <= GW'(`PWSC_LOCK_GUARD_CYC);
    end else if (ce) begin
      if (state != PWSC_ST_WAIT) begin
        guard_cnt <= GW'(`PWSC_LOCK_GUARD_CYC);
      end else if (guard_cnt != '0) begin
        guard_cnt <= guard_cnt - GW'(1);
      end
    end
  end
  assign guard_done = (guard_cnt == '0); // RULE4 RULE18

  ////////////////////////////////////////////////////////////////////////////
  // loop reset and system reset
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_reset <= 1'b1;
      sys_reset <= 1'b1;
    end else if (ce) begin
      loop_reset <= next_loop_reset; // RULE5 RULE6
      sys_reset <= (state != PWSC_ST_RUN) || next_loop_reset; // RULE4 RULE5
    end
  end

  // loop enable
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_enable <= 1'b1;
    end else if (ce) begin
      loop_enable <= HAS_ENABLE_IN ? loop_enable_in : 1'b1; // RULE9
    end
  end

  // detector enable; register variants never look at the pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      loop_pfd_enable <= 1'b1;
    end else if (ce) begin
      if (BUILTIN_REGS || PFD_MODE == PWSC_REGISTER) begin
        loop_pfd_enable <= ctrl[`PWSC_CTRL_PFD_BIT]; // RULE7 RULE10
      end else begin
        loop_pfd_enable <= HAS_PFD_IN ? pfd_enable_in : 1'b1; // RULE10
      end
    end
  end

  // lock port mirrors the raw lock, unsynchronised like the loop's own pin
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      locked <= 1'b0;
    end else if (ce) begin
      locked <= loop_locked_raw; // RULE11
    end
  end

  // status word: only synchronised copies reach software
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      status_rdata <= `PWSC_STAT_RST; // RULE13
    end else if (ce) begin
      status_rdata[`PWSC_STAT_LOCK_BIT] <= synced[`PWSC_STAT_LOCK_BIT]; // RULE13
      status_rdata[`PWSC_STAT_PDONE_BIT] <= synced[`PWSC_STAT_PDONE_BIT]; // RULE16
    end
  end

  // control read-back, one cycle behind the control word
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_rdata <= `PWSC_CTRL_RST;
    end else if (ce) begin
      ctrl_rdata <= ctrl;
    end
  end
  // clocks of the loop never pass through this block RULE12
endmodule
`default_nettype wire

// ### verilog/pwsc_params.svh
// Purpose: constants for the loop wrapper
// Assumes: one system clock at 25 MHz
// Notes: bit positions of status and control words
`ifndef PWSC_PARAMS_SVH
`define PWSC_PARAMS_SVH
`define PWSC_STAT_LOCK_BIT 0
`define PWSC_STAT_PDONE_BIT 1
`define PWSC_CTRL_RESET_BIT 0
`define PWSC_CTRL_PFD_BIT 1
`define PWSC_STAT_RST 2'h1
`define PWSC_CTRL_RST 2'h2
`define PWSC_CLK_NS 40
`define PWSC_PULSE_NS 400
`define PWSC_PULSE_CYC ((`PWSC_PULSE_NS + `PWSC_CLK_NS - 1) / `PWSC_CLK_NS)
`define PWSC_LOCK_GUARD_CYC 3
`endif

// ### verilog/pwsc_pkg.sv
// Purpose: types for the loop wrapper
// Assumes: nothing
// Notes: mode select per optional signal
`default_nettype none
package pwsc_pkg;
  typedef enum logic [0:0] {
    PWSC_EXPORT = 1'b0,
    PWSC_REGISTER = 1'b1
  } pwsc_mode_t;
  typedef enum logic [1:0] {
    PWSC_ST_CONFIG = 2'b00,
    PWSC_ST_WAIT = 2'b01,
    PWSC_ST_RUN = 2'b10
  } pwsc_state_t;
endpackage
`default_nettype wire

// ### verilog/pwsc_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: async inputs
// Notes: first stage feeds only the second
`default_nettype none
module pwsc_sync #(
  parameter int WIDTH = 2
) (
  input wire logic clk, // system clock
  input wire logic rst, // async reset
  input wire logic ce, // clock enable
  input wire logic [WIDTH-1:0] d, // async level
  output logic [WIDTH-1:0] q // synchronised level
);
  logic [WIDTH-1:0] meta;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else if (ce) begin
      meta <= d;
      q <= meta;
    end
  end
endmodule
`default_nettype wire

// ### test/pwsc_top_assertions.sv
// Purpose: port checker for the loop wrapper
// Assumes: ce held high
// Notes: bound to pwsc_top
`default_nettype none
module pwsc_top_assertions (
  input wire logic clk, // clock
  input wire logic rst, // reset
  input wire logic ctrl_wr, // ctrl strobe
  input wire logic [1:0] ctrl_wdata, // ctrl data
  input wire logic loop_enable_in, // enable in
  input wire logic loop_locked_raw, // raw lock
  input wire logic loop_phase_done_raw, // raw done
  input wire logic [1:0] status_rdata, // status
  input wire logic loop_reset, // loop reset
  input wire logic loop_enable, // loop enable
  input wire logic loop_pfd_enable, // detector
  input wire logic locked, // lock port
  input wire logic sys_reset // sys reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  property p_sys; $rose(loop_reset) |-> ##[0:1] sys_reset; endproperty
  a_sys: assert property (p_sys) else $error("loop reset left system running");
  property p_rel; $fell(sys_reset) |-> status_rdata[0] || $past(status_rdata[0]); endproperty
  a_rel: assert property (p_rel) else $error("release without lock");
  property p_meta; $fell(sys_reset) |-> $past(locked, 2); endproperty
  a_meta: assert property (p_meta) else $error("release on unsettled lock");
  property p_lock; locked == $past(loop_locked_raw); endproperty
  a_lock: assert property (p_lock) else $error("lock port wrong");
  // a raw edge must not reach the status word in one clock
  property p_pd; $rose(loop_phase_done_raw) ##0 !status_rdata[1] |=> !status_rdata[1]; endproperty
  a_pd: assert property (p_pd) else $error("phase done not synchronised");
  property p_req; ctrl_wr && ctrl_wdata[0] |-> ##[1:3] (loop_reset && sys_reset); endproperty
  a_req: assert property (p_req) else $error("reset bit ignored");
  property p_pfd; ctrl_wr && !ctrl_wdata[1] |-> ##[1:3] !loop_pfd_enable; endproperty
  a_pfd: assert property (p_pfd) else $error("detector not disabled");
  property p_pulse; $rose(loop_reset) |-> loop_reset[*2]; endproperty
  a_pulse: assert property (p_pulse) else $error("loop reset too short");
  property p_en; $fell(loop_enable_in) |-> ##[1:2] !loop_enable; endproperty
  a_en: assert property (p_en) else $error("enable not followed");
  c_rel: cover property ($fell(sys_reset));
  c_pfd: cover property ($fell(loop_pfd_enable));
  c_pd: cover property ($rose(status_rdata[1]));
endmodule
bind pwsc_top pwsc_top_assertions u_chk (.clk(clk), .rst(rst), .ctrl_wr(ctrl_wr),
  .ctrl_wdata(ctrl_wdata), .loop_enable_in(loop_enable_in), .loop_locked_raw(loop_locked_raw),
  .loop_phase_done_raw(loop_phase_done_raw), .status_rdata(status_rdata),
  .loop_reset(loop_reset), .loop_enable(loop_enable), .loop_pfd_enable(loop_pfd_enable),
  .locked(locked), .sys_reset(sys_reset));
`default_nettype wire

// ### test/pwsc_loop_model.sv
// Purpose: behavioural loop that locks after a settle time
// Assumes: lock only while out of reset and enabled
// Notes: settle time is a plain default
`default_nettype none
module pwsc_loop_model #(
  parameter int SETTLE = 5 // cycles to lock
) (
  input wire logic clk, // reference clock
  input wire logic loop_reset, // reset in
  input wire logic loop_enable, // enable in
  output logic loop_locked_raw // lock out
);
  int cnt;
  // reset or disable restarts acquisition from scratch
  always_ff @(posedge clk) begin
    if (loop_reset || !loop_enable) cnt <= 0;
    else if (cnt < SETTLE) cnt <= cnt + 1;
  end
  assign loop_locked_raw = (cnt == SETTLE);
endmodule
`default_nettype wire

// ### test/pwsc_top_bench.sv
// Purpose: directed bench for the loop wrapper
// Assumes: built-in register variant, pulse of 2
// Notes: ce tied high
`default_nettype none
module pwsc_top_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, ce = 1'h1, loop_reset_in = 1'h0, loop_enable_in = 1'h1;
  logic pfd_enable_in = 1'h1, status_wr = 1'h0, ctrl_wr = 1'h0, loop_phase_done_raw = 1'h0;
  logic [1:0] status_wdata = 2'h0, ctrl_wdata = 2'h0, status_rdata, ctrl_rdata;
  logic loop_locked_raw, loop_reset, loop_enable, loop_pfd_enable, locked, sys_reset;
  int err_count = 0, total_checks = 0;
  always #20 clk = ~clk;
  pwsc_top #(.BUILTIN_REGS(1'h1), .PULSE_CYC(2)) dut (.clk(clk), .rst(rst), .ce(ce),
    .loop_reset_in(loop_reset_in), .loop_enable_in(loop_enable_in), .status_wr(status_wr),
    .pfd_enable_in(pfd_enable_in), .status_wdata(status_wdata), .ctrl_wr(ctrl_wr),
    .ctrl_wdata(ctrl_wdata), .loop_locked_raw(loop_locked_raw), .locked(locked),
    .loop_phase_done_raw(loop_phase_done_raw), .status_rdata(status_rdata),
    .ctrl_rdata(ctrl_rdata), .loop_reset(loop_reset), .loop_enable(loop_enable),
    .loop_pfd_enable(loop_pfd_enable), .sys_reset(sys_reset));
  pwsc_loop_model loop (.clk(clk), .loop_reset(loop_reset), .loop_enable(loop_enable),
    .loop_locked_raw(loop_locked_raw));
  task automatic chk(input string n, input logic [1:0] e, input logic [1:0] s);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_sys(input logic v);
    for (int i = 0; i < 60 && sys_reset !== v; i++) cyc(1);
    if (sys_reset !== v) begin
      err_count++;
      $display("CHECK FAILED sys_reset wait expected %h seen %h", v, sys_reset);
      give_verdict();
    end
  endtask
  task automatic ctrl(input logic [1:0] d);
    @(posedge clk);
    ctrl_wr <= 1'h1;
    ctrl_wdata <= d;
    @(posedge clk);
    ctrl_wr <= 1'h0;
    cyc(2);
  endtask
  task give_verdict;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (5) cyc(1);
    chk("status rst", 2'h1, status_rdata);
    chk("ctrl rst", 2'h2, ctrl_rdata);
    @(posedge clk) rst <= 1'h0;
    cyc(1);
    chk("config pulse", 2'h3, {loop_reset, sys_reset});
    wait_sys(1'h0);
    chk("lock at release", 2'h3, {locked, status_rdata[0]});
    $display("reset test done");
    @(posedge clk) pfd_enable_in <= 1'h0;
    ctrl(2'h0);
    chk("ctrl read", 2'h0, ctrl_rdata);
    chk("pfd off", 2'h0, {1'h0, loop_pfd_enable});
    @(posedge clk) status_wr <= 1'h1;
    @(posedge clk) status_wr <= 1'h0;
    cyc(2);
    chk("status after write", 2'h1, status_rdata);
    chk("ctrl after status write", 2'h0, ctrl_rdata);
    ctrl(2'h2);
    chk("pfd from bit only", 2'h1, {1'h0, loop_pfd_enable});
    $display("control test done");
    ctrl(2'h3);
    chk("bit reset", 2'h3, {loop_reset, sys_reset});
    cyc(3);
    chk("held through stale lock", 2'h1, {1'h0, sys_reset});
    wait_sys(1'h0);
    chk("reset bit clears", 2'h2, ctrl_rdata);
    @(posedge clk) loop_reset_in <= 1'h1;
    @(posedge clk) loop_reset_in <= 1'h0;
    cyc(1);
    chk("port reset", 2'h3, {loop_reset, sys_reset});
    wait_sys(1'h0);
    $display("loop reset test done");
    @(posedge clk) loop_enable_in <= 1'h0;
    wait_sys(1'h1);
    chk("enable off", 2'h0, {loop_enable, status_rdata[0]});
    @(posedge clk) loop_enable_in <= 1'h1;
    wait_sys(1'h0);
    @(posedge clk) loop_phase_done_raw <= 1'h1;
    cyc(1);
    chk("done not yet", 2'h1, status_rdata);
    cyc(3);
    chk("done seen", 2'h3, status_rdata);
    $display("status test done");
    give_verdict();
  end
endmodule
`default_nettype wire
